// file: rtl/tcs_cksum.sv
`timescale 1ns/100ps
// =====================================================================
// running checksum over the calibration block as it is written
// =====================================================================
module tcs_cksum (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic add_in,
  input wire logic start_in,
  input wire logic [7:0] byte_in,
  output logic [7:0] sum_out
);
  logic [7:0] sum_q;
  logic [7:0] sum_d;

  // the key byte restarts from the seed; carries out of bit 7 drop
  always_comb begin
    sum_d = sum_q;
    if (add_in) begin
      sum_d = start_in ? 8'(tcs_pkg::CAL_SEED + byte_in)
                       : 8'(sum_q + byte_in);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sum_q <= tcs_pkg::CAL_SEED;
    end else begin
      sum_q <= sum_d;
    end
  end

  assign sum_out = sum_q;

  property p_seeded_sum;
    @(posedge ref_clk_in) disable iff (rst_in)
    (add_in && start_in) |=> sum_q == 8'($past(byte_in) + 8'h45);
  endproperty
  a_seeded_sum: assert property (p_seeded_sum)
    else $error("checksum not restarted from seed");

endmodule // tcs_cksum

// file: rtl/tcs_pkg.sv
package tcs_pkg;

  // =====================================================================
  // framing and command codes
  // =====================================================================
  localparam logic [7:0] FRAME_HDR = 8'h55;
  localparam logic [7:0] CMD_TOUCH_ON = 8'h12;
  localparam logic [7:0] CMD_TOUCH_OFF = 8'h13;
  localparam logic [7:0] CMD_CAL_MODE = 8'h14;
  localparam logic [7:0] CAL_MODE_ARG = 8'h04;
  localparam logic [7:0] CMD_REG_WR = 8'h21;
  localparam logic [7:0] CMD_REG_BASE = 8'h22;
  localparam logic [7:0] CMD_REGS_PERSIST = 8'h23;
  localparam logic [7:0] CMD_NVM_WR = 8'h29;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_BAD_CMD = 8'h03;
  localparam logic [7:0] ST_BAD_ARG = 8'h04;
  localparam logic [7:0] ACK_LEN = 8'h02;
  localparam logic [7:0] BASE_LEN = 8'h03;
  localparam logic [7:0] WR_MAX = 8'h08;
  localparam logic [7:0] BODY_MAX = 8'h0C;
  localparam int CORNERS = 4;

  // =====================================================================
  // registers and calibration block
  // =====================================================================
  localparam logic [7:0] REG_BASE_RST = 8'h20;
  localparam logic [7:0] OPT_OFFSET = 8'h0D;
  localparam int OPT_CCE_BIT = 0;
  localparam int OPT_WIRE_BIT = 1;
  localparam logic [1:0] OPT_RST = 2'h0;
  localparam logic [7:0] CAL_KEY_ADDR = 8'h16;
  localparam logic [7:0] CAL_SUM_ADDR = 8'h28;
  localparam logic [7:0] CAL_SEED = 8'h45;

  typedef enum logic [6:0] {
    S_HDR = 7'h01,
    S_LEN = 7'h02,
    S_BODY = 7'h04,
    S_EXEC = 7'h08,
    S_NVW = 7'h10,
    S_TX = 7'h20,
    S_STORE = 7'h40
  } tcs_state_type;

  typedef logic [4:0][7:0] tcs_frame_type;

  typedef struct packed {
    tcs_state_type st;
    logic [7:0] len;
    logic [3:0] idx;
    logic [11:0][7:0] body;
    logic [1:0] opts;
    logic touch_en;
    logic cal_mode;
    logic [2:0] corner;
    logic corner_pend;
    logic store_after;
    tcs_frame_type tx_buf;
    logic [2:0] tx_len;
    logic [2:0] tx_idx;
    logic [3:0] nvw_i;
    logic nvm_we;
    logic [7:0] nvm_addr;
    logic [7:0] nvm_data;
    logic persist;
    logic store_req;
    logic booted;
    logic cal_use;
    logic cal_ok;
  } tcs_regs_type;

  // four-byte answer: header, length, status, echoed command
  function automatic tcs_frame_type tcs_ack(input logic [7:0] status,
                                           input logic [7:0] cmd);
    tcs_ack = {8'h00, cmd, status, ACK_LEN, FRAME_HDR};
  endfunction

endpackage

// file: rtl/tcs_seq.sv
`timescale 1ns/100ps
// Overview of operation
// - ack each touched corner with calibrate identifier
// - extra calibrate ack once data is stored
// - enable frame 0x12 answered with status echo
// - checksum: seed 0x45 plus 18 bytes, 8-bit
// - option bit 0 enables calibrated coordinates
// - option bit 1 picks eight or four wire
// - option bits 7..2 read as zero
// - stored calibration used only after power cycle
// - frames start 0x55 then byte count
// - nvm write: high 0x00, low, count 1..8
// - finished calibration stored and coordinates enabled
module tcs_seq #(
  parameter bit HAS_DONE_REPORT = 1'b1,
  parameter logic [7:0] REG_BASE = tcs_pkg::REG_BASE_RST
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  output logic [7:0] tx_byte_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic corner_touch_in,
  output logic cal_store_req_out,
  input wire logic cal_store_done_in,
  input wire logic [1:0] boot_opts_in,
  input wire logic cal_present_in,
  output logic nvm_we_out,
  output logic [7:0] nvm_addr_out,
  output logic [7:0] nvm_data_out,
  output logic regs_persist_cmd_out,
  output logic [7:0] touch_option_flags_out,
  output logic calibrated_coords_enable_out,
  output logic sensor_wire_select_out,
  output logic touch_enable_out,
  output logic cal_mode_out,
  output logic cal_block_ok_out
);
  tcs_pkg::tcs_regs_type q;
  tcs_pkg::tcs_regs_type d;
  logic [7:0] sum;
  logic [7:0] cmd;
  logic [7:0] cnt;
  logic wr_ok;
  logic take;

  assign cmd = q.body[0];
  assign cnt = q.body[3];
  // address high byte zero, count 1..8 and length matching the count
  assign wr_ok = (q.body[1] == 8'h00) && (cnt != 8'h00)
    && (cnt <= tcs_pkg::WR_MAX) && (q.len == 8'(cnt + 8'h04));
  // a pending corner ack goes out before the next frame is accepted
  assign take = rx_valid_in && rx_ready_out;
  assign rx_ready_out = ((q.st == tcs_pkg::S_HDR)
    && !(q.corner_pend && q.cal_mode)) || (q.st == tcs_pkg::S_LEN)
    || (q.st == tcs_pkg::S_BODY);

  // =====================================================================
  // command interpreter
  // =====================================================================
  always_comb begin
    d = q;
    d.nvm_we = 1'b0;
    d.persist = 1'b0;
    // the stored checksum byte is compared with the running sum
    if (q.nvm_we && q.nvm_addr == tcs_pkg::CAL_SUM_ADDR) begin
      d.cal_ok = (q.nvm_data == sum);
    end
    if (corner_touch_in && q.cal_mode) begin
      d.corner_pend = 1'b1;
    end
    // stored options and calibration are taken up only at power-up
    if (!q.booted) begin
      d.booted = 1'b1;
      d.opts = boot_opts_in;
      d.cal_use = cal_present_in;
    end
    unique case (q.st)
      tcs_pkg::S_HDR: begin
        if (q.corner_pend && q.cal_mode) begin
          d.tx_buf = tcs_pkg::tcs_ack(tcs_pkg::ST_OK,
                                      tcs_pkg::CMD_CAL_MODE);
          d.tx_len = 3'h4;
          d.tx_idx = 3'h0;
          d.corner_pend = corner_touch_in;
          d.corner = 3'(q.corner + 3'h1);
          d.store_after = (q.corner == 3'(tcs_pkg::CORNERS - 1));
          d.st = tcs_pkg::S_TX;
        end else if (take && rx_byte_in == tcs_pkg::FRAME_HDR) begin
          d.st = tcs_pkg::S_LEN;
        end
      end
      tcs_pkg::S_LEN: begin
        if (take) begin
          d.len = rx_byte_in;
          d.idx = 4'h0;
          // an empty or oversize body cannot be a command: resync
          d.st = (rx_byte_in == 8'h00 || rx_byte_in > tcs_pkg::BODY_MAX)
            ? tcs_pkg::S_HDR : tcs_pkg::S_BODY;
        end
      end
      tcs_pkg::S_BODY: begin
        if (take) begin
          d.body[q.idx] = rx_byte_in;
          d.idx = 4'(q.idx + 4'h1);
          if (8'(q.idx + 4'h1) == q.len) begin
            d.st = tcs_pkg::S_EXEC;
          end
        end
      end
      tcs_pkg::S_EXEC: begin
        d.tx_len = 3'h4;
        d.tx_idx = 3'h0;
        d.st = tcs_pkg::S_TX;
        d.tx_buf = tcs_pkg::tcs_ack(tcs_pkg::ST_OK, cmd);
        // any command other than calibrate cancels calibration
        if (cmd != tcs_pkg::CMD_CAL_MODE) begin
          d.cal_mode = 1'b0;
        end
        unique case (cmd)
          tcs_pkg::CMD_TOUCH_ON: begin
            d.touch_en = 1'b1;
          end
          tcs_pkg::CMD_TOUCH_OFF: begin
            d.touch_en = 1'b0;
          end
          tcs_pkg::CMD_CAL_MODE: begin
            if (q.len == 8'h02 && q.body[1] == tcs_pkg::CAL_MODE_ARG) begin
              d.cal_mode = 1'b1;
              d.corner = 3'h0;
              d.corner_pend = 1'b0;
            end else begin
              d.tx_buf = tcs_pkg::tcs_ack(tcs_pkg::ST_BAD_ARG, cmd);
            end
          end
          tcs_pkg::CMD_REG_BASE: begin
            d.tx_buf = {REG_BASE, cmd, tcs_pkg::ST_OK, tcs_pkg::BASE_LEN,
                        tcs_pkg::FRAME_HDR};
            d.tx_len = 3'h5;
          end
          tcs_pkg::CMD_REG_WR: begin
            if (wr_ok) begin
              // only the option register is held here; others are ignored
              for (int i = 0; i < 8; i++) begin
                if (8'(i) < cnt && 8'(q.body[2] + 8'(i))
                    == 8'(REG_BASE + tcs_pkg::OPT_OFFSET)) begin
                  d.opts = q.body[4 + i][1:0];
                end
              end
            end else begin
              d.tx_buf = tcs_pkg::tcs_ack(tcs_pkg::ST_BAD_ARG, cmd);
            end
          end
          tcs_pkg::CMD_REGS_PERSIST: begin
            d.persist = 1'b1;
          end
          tcs_pkg::CMD_NVM_WR: begin
            if (wr_ok) begin
              d.nvw_i = 4'h0;
              d.st = tcs_pkg::S_NVW;
            end else begin
              d.tx_buf = tcs_pkg::tcs_ack(tcs_pkg::ST_BAD_ARG, cmd);
            end
          end
          default: begin
            d.tx_buf = tcs_pkg::tcs_ack(tcs_pkg::ST_BAD_CMD, cmd);
          end
        endcase
      end
      tcs_pkg::S_NVW: begin
        // one byte per cycle; the answer starts in the same cycle as the last write strobe
        d.nvm_we = 1'b1;
        d.nvm_addr = 8'(q.body[2] + 8'(q.nvw_i));
        d.nvm_data = q.body[4 + q.nvw_i];
        d.nvw_i = 4'(q.nvw_i + 4'h1);
        if (8'(q.nvw_i + 4'h1) == cnt) begin
          d.st = tcs_pkg::S_TX;
        end
      end
      tcs_pkg::S_TX: begin
        if (tx_ready_in) begin
          d.tx_idx = 3'(q.tx_idx + 3'h1);
          if (3'(q.tx_idx + 3'h1) == q.tx_len) begin
            d.st = q.store_after ? tcs_pkg::S_STORE : tcs_pkg::S_HDR;
            d.store_req = q.store_after;
            d.store_after = 1'b0;
          end
        end
      end
      tcs_pkg::S_STORE: begin
        if (cal_store_done_in) begin
          d.store_req = 1'b0;
          d.cal_mode = 1'b0;
          d.cal_use = 1'b1;
          d.opts[tcs_pkg::OPT_CCE_BIT] = 1'b1;
          d.st = HAS_DONE_REPORT ? tcs_pkg::S_TX : tcs_pkg::S_HDR;
          d.tx_buf = tcs_pkg::tcs_ack(tcs_pkg::ST_OK,
                                      tcs_pkg::CMD_CAL_MODE);
          d.tx_len = 3'h4;
          d.tx_idx = 3'h0;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      q <= '{st: tcs_pkg::S_HDR, opts: tcs_pkg::OPT_RST,
             tx_len: 3'h4, default: '0};
    end else begin
      q <= d;
    end
  end

  // =====================================================================
  // calibration block check on the first image
  // =====================================================================
  tcs_cksum u_cksum (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .add_in(q.nvm_we && q.nvm_addr >= tcs_pkg::CAL_KEY_ADDR
            && q.nvm_addr < tcs_pkg::CAL_SUM_ADDR),
    .start_in(q.nvm_addr == tcs_pkg::CAL_KEY_ADDR),
    .byte_in(q.nvm_data),
    .sum_out(sum)
  );

  // =====================================================================
  // outputs
  // =====================================================================
  assign tx_valid_out = (q.st == tcs_pkg::S_TX);
  assign tx_byte_out = q.tx_buf[q.tx_idx];
  assign cal_store_req_out = q.store_req;
  assign nvm_we_out = q.nvm_we;
  assign nvm_addr_out = q.nvm_addr;
  assign nvm_data_out = q.nvm_data;
  assign regs_persist_cmd_out = q.persist;
  assign touch_option_flags_out = {6'h00, q.opts};
  assign calibrated_coords_enable_out =
    q.opts[tcs_pkg::OPT_CCE_BIT] && q.cal_use;
  assign sensor_wire_select_out = q.opts[tcs_pkg::OPT_WIRE_BIT];
  assign touch_enable_out = q.touch_en;
  assign cal_mode_out = q.cal_mode;
  assign cal_block_ok_out = q.cal_ok;

  // =====================================================================
  // checks
  // =====================================================================
  property p_hdr_first;
    @(posedge ref_clk_in) disable iff (rst_in)
    (tx_valid_out && q.tx_idx == 3'h0) |-> tx_byte_out == 8'h55;
  endproperty
  a_hdr_first: assert property (p_hdr_first)
    else $error("frame does not open with header byte");

  property p_corner_ack;
    @(posedge ref_clk_in) disable iff (rst_in)
    (q.st == tcs_pkg::S_HDR && q.corner_pend && q.cal_mode)
      |=> tx_valid_out && q.tx_buf[3] == 8'h14 && q.tx_buf[2] == 8'h00;
  endproperty
  a_corner_ack: assert property (p_corner_ack)
    else $error("corner not acknowledged");

  property p_done_report;
    @(posedge ref_clk_in) disable iff (rst_in)
    (q.st == tcs_pkg::S_STORE && cal_store_done_in && HAS_DONE_REPORT)
      |=> tx_valid_out && q.tx_buf[3] == 8'h14 ##0 !q.cal_mode;
  endproperty
  a_done_report: assert property (p_done_report)
    else $error("no completion report after store");

  property p_auto_cce;
    @(posedge ref_clk_in) disable iff (rst_in)
    (q.st == tcs_pkg::S_STORE && cal_store_done_in)
      |=> calibrated_coords_enable_out;
  endproperty
  a_auto_cce: assert property (p_auto_cce)
    else $error("calibration end did not enable coordinates");

  property p_enable_touch;
    @(posedge ref_clk_in) disable iff (rst_in)
    (q.st == tcs_pkg::S_EXEC && cmd == 8'h12)
      |=> touch_enable_out && tx_valid_out && q.tx_buf[3] == 8'h12;
  endproperty
  a_enable_touch: assert property (p_enable_touch)
    else $error("enable frame not answered");

  property p_bad_write;
    @(posedge ref_clk_in) disable iff (rst_in)
    (q.st == tcs_pkg::S_EXEC && cmd == 8'h29 && (cnt == 8'h00
      || cnt > 8'h08)) |=> tx_valid_out && q.tx_buf[2] != 8'h00
      ##1 !nvm_we_out;
  endproperty
  a_bad_write: assert property (p_bad_write)
    else $error("bad write count accepted");

  property p_opt_zero;
    @(posedge ref_clk_in) disable iff (rst_in)
    touch_option_flags_out[7:2] == 6'h00
      && sensor_wire_select_out == touch_option_flags_out[1];
  endproperty
  a_opt_zero: assert property (p_opt_zero)
    else $error("option register upper bits not zero");

  property p_cce_gate;
    @(posedge ref_clk_in) disable iff (rst_in)
    calibrated_coords_enable_out |-> touch_option_flags_out[0];
  endproperty
  a_cce_gate: assert property (p_cce_gate)
    else $error("calibrated coordinates without option bit");

  property p_cal_after_boot;
    @(posedge ref_clk_in) disable iff (rst_in)
    ($past(q.booted) && $past(q.st) != tcs_pkg::S_STORE)
      |-> $stable(q.cal_use);
  endproperty
  a_cal_after_boot: assert property (p_cal_after_boot)
    else $error("stored calibration taken up without power cycle");

endmodule // tcs_seq

// file: sim/tcs_host.sv
`timescale 1ns/100ps
// =====================================================================
// host processor model: frames commands and collects the answers
// =====================================================================
module tcs_host (
  input wire logic ref_clk_in,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out
);
  bit slow = 1'b0;

  // idle: valid low, data parked on a filler so stale bytes never match
  initial begin
    rx_byte_out = 8'ha5;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b1;
  end

  // slow mode holds off every answer byte to exercise the stall path
  task automatic set_slow(input bit s);
    @(posedge ref_clk_in);
    slow = s;
    tx_ready_out <= !s;
  endtask

  // header and byte count go in front of every body
  task automatic send(input logic [7:0] b [$]);
    logic [7:0] f [$];
    int n;
    f = {tcs_pkg::FRAME_HDR, 8'(b.size())};
    f = {f, b};
    @(posedge ref_clk_in);
    foreach (f[i]) begin
      rx_byte_out <= f[i];
      rx_valid_out <= 1'b1;
      n = 0;
      do begin
        @(negedge ref_clk_in);
        n++;
      end while (rx_ready_in !== 1'b1 && n < 1000);
      @(posedge ref_clk_in);
    end
    rx_valid_out <= 1'b0;
    rx_byte_out <= ~f[f.size() - 1];
  endtask

  // one answer byte; in slow mode ready rises only after the byte has been seen, otherwise it stays high
  task automatic get_byte(output logic [7:0] b);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (tx_valid_in !== 1'b1 && n < 2000);
    b = tx_byte_in;
    if (slow) begin
      repeat (2) @(posedge ref_clk_in);
      tx_ready_out <= 1'b1;
    end
    @(posedge ref_clk_in);
    if (slow) tx_ready_out <= 1'b0;
  endtask

  // whole answer frame, length taken from its own count byte
  task automatic get(output logic [7:0] r [$]);
    logic [7:0] b;
    r = {};
    do begin
      get_byte(b);
      r.push_back(b);
    end while ((r.size() < 2 || r.size() < int'(r[1]) + 2) && r.size() < 8);
  endtask
endmodule // tcs_host

// file: sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] rx_byte_in, tx_byte_out, nvm_addr_out, nvm_data_out;
  logic rx_valid_in, rx_ready_out, tx_valid_out, tx_ready_in;
  logic corner_touch_in = 1'b0;
  logic cal_store_done_in = 1'b0;
  logic [1:0] boot_opts_in = 2'b00;
  logic cal_present_in = 1'b0;
  logic cal_store_req_out, nvm_we_out, regs_persist_cmd_out, cal_mode_out;
  logic [7:0] touch_option_flags_out;
  logic calibrated_coords_enable_out, sensor_wire_select_out;
  logic touch_enable_out, cal_block_ok_out;
  logic [7:0] nvm_img [256];
  int nvm_cnt = 0;
  int persist_cnt = 0;
  int num_errors = 0;
  int checks_done = 0;

  always #20 ref_clk_in = ~ref_clk_in;

  tcs_seq #(.HAS_DONE_REPORT(1'b1), .REG_BASE(tcs_pkg::REG_BASE_RST))
  tcs_seq_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .rx_byte_in(rx_byte_in), .rx_valid_in(rx_valid_in),
    .rx_ready_out(rx_ready_out), .tx_byte_out(tx_byte_out),
    .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
    .corner_touch_in(corner_touch_in),
    .cal_store_req_out(cal_store_req_out),
    .cal_store_done_in(cal_store_done_in), .boot_opts_in(boot_opts_in),
    .cal_present_in(cal_present_in), .nvm_we_out(nvm_we_out),
    .nvm_addr_out(nvm_addr_out), .nvm_data_out(nvm_data_out),
    .regs_persist_cmd_out(regs_persist_cmd_out),
    .touch_option_flags_out(touch_option_flags_out),
    .calibrated_coords_enable_out(calibrated_coords_enable_out),
    .sensor_wire_select_out(sensor_wire_select_out),
    .touch_enable_out(touch_enable_out), .cal_mode_out(cal_mode_out),
    .cal_block_ok_out(cal_block_ok_out));

  tcs_host tcs_host_i (.ref_clk_in(ref_clk_in), .rx_byte_out(rx_byte_in),
    .rx_valid_out(rx_valid_in), .rx_ready_in(rx_ready_out),
    .tx_byte_in(tx_byte_out), .tx_valid_in(tx_valid_out),
    .tx_ready_out(tx_ready_in));

  // =====================================================================
  // memory image, one byte per cycle of nvm_we, and persist strobe, a single-cycle pulse
  // =====================================================================
  always @(posedge ref_clk_in) begin
    if (nvm_we_out === 1'b1) begin
      nvm_img[nvm_addr_out] = nvm_data_out;
      nvm_cnt++;
    end
    if (regs_persist_cmd_out === 1'b1) persist_cnt++;
  end

  // =====================================================================
  // compare, frame and reset helpers
  // =====================================================================
  task automatic check_byte(input string what, input logic [7:0] exp,
                            input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_ack(input logic [7:0] r [$], input logic [7:0] st,
                         input logic [7:0] id);
    check_byte("ack header", tcs_pkg::FRAME_HDR, r[0]);
    check_byte("ack length", tcs_pkg::ACK_LEN, r[1]);
    check_byte("ack status", st, r[2]);
    check_byte("ack command", id, r[3]);
    check_byte("ack size", 8'h04, 8'(r.size()));
  endtask

  // every answer is inspected, not only waited for
  task automatic run(input logic [7:0] b [$], input logic [7:0] st);
    logic [7:0] r [$];
    tcs_host_i.send(b);
    tcs_host_i.get(r);
    chk_ack(r, st, b[0]);
  endtask

  task automatic do_reset(input logic [1:0] opts, input logic present);
    @(posedge ref_clk_in);
    boot_opts_in <= opts;
    cal_present_in <= present;
    rst_in <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // a hung handshake must still end the run with a verdict
  initial begin
    repeat (40000) @(posedge ref_clk_in);
    num_errors++;
    print_verdict();
  end

  // =====================================================================
  // main sequence
  // =====================================================================
  initial begin
    logic [7:0] r [$];
    logic [7:0] blk [19];
    logic [7:0] a;
    int n;
    blk = '{8'h55, 8'h06, 8'h1b, 8'ha5, 8'h08, 8'h13, 8'hdf, 8'hf4, 8'h0b,
      8'h98, 8'he4, 8'h1e, 8'hec, 8'hbf, 8'h1a, 8'h32, 8'he7, 8'h01, 8'h00};
    blk[18] = tcs_pkg::CAL_SEED;
    for (int i = 0; i < 18; i++) blk[18] = blk[18] + blk[i];
    do_reset(2'b00, 1'b0);
    check_byte("options at reset", 8'h00, touch_option_flags_out);
    check_byte("ready at reset", 8'h01, {7'h00, rx_ready_out});
    run({tcs_pkg::CMD_TOUCH_OFF}, tcs_pkg::ST_OK);
    // malformed and unknown commands are answered but write nothing
    run({8'h77}, tcs_pkg::ST_BAD_CMD);
    run({tcs_pkg::CMD_NVM_WR, 8'h00, 8'h80, 8'h00}, tcs_pkg::ST_BAD_ARG);
    run({tcs_pkg::CMD_NVM_WR, 8'h01, 8'h80, 8'h01, 8'haa}, tcs_pkg::ST_BAD_ARG);
    run({tcs_pkg::CMD_NVM_WR, 8'h00, 8'h80, 8'h02, 8'haa}, tcs_pkg::ST_BAD_ARG);
    run({tcs_pkg::CMD_CAL_MODE, 8'h05}, tcs_pkg::ST_BAD_ARG);
    check_byte("refused writes", 8'h00, 8'(nvm_cnt));
    // key, data and checksum, then the mirror image
    for (int img = 0; img < 2; img++) begin
      for (int k = 0; k < 3; k++) begin
        n = (k == 2) ? 3 : 8;
        a = (img == 0 ? tcs_pkg::CAL_KEY_ADDR : 8'h3e) + 8'(8 * k);
        r = {tcs_pkg::CMD_NVM_WR, 8'h00, a, 8'(n)};
        for (int i = 0; i < n; i++) r.push_back(blk[8 * k + i]);
        run(r, tcs_pkg::ST_OK);
      end
      if (img == 0) check_byte("block ok", 8'h01, {7'h00, cal_block_ok_out});
    end
    check_byte("write count", 8'h26, 8'(nvm_cnt));
    for (int i = 0; i < 19; i++) begin
      check_byte("image one", blk[i], nvm_img[8'h16 + i]);
      check_byte("image two", blk[i], nvm_img[8'h3e + i]);
    end
    // option register through base query, write, persist
    tcs_host_i.send({tcs_pkg::CMD_REG_BASE});
    tcs_host_i.get(r);
    check_byte("base length", tcs_pkg::BASE_LEN, r[1]);
    check_byte("base status", tcs_pkg::ST_OK, r[2]);
    check_byte("base value", tcs_pkg::REG_BASE_RST, r[4]);
    a = r[4] + tcs_pkg::OPT_OFFSET;
    run({tcs_pkg::CMD_REG_WR, 8'h00, a, 8'h01, 8'hff}, tcs_pkg::ST_OK);
    check_byte("options all ones", 8'h03, touch_option_flags_out);
    check_byte("eight wire", 8'h01, {7'h00, sensor_wire_select_out});
    check_byte("no cal yet", 8'h00, {7'h00, calibrated_coords_enable_out});
    run({tcs_pkg::CMD_REG_WR, 8'h00, a, 8'h01, 8'h01}, tcs_pkg::ST_OK);
    check_byte("options cce", 8'h01, touch_option_flags_out);
    check_byte("four wire", 8'h00, {7'h00, sensor_wire_select_out});
    check_byte("still raw", 8'h00, {7'h00, calibrated_coords_enable_out});
    run({tcs_pkg::CMD_REGS_PERSIST}, tcs_pkg::ST_OK);
    check_byte("persist pulses", 8'h01, 8'(persist_cnt));
    run({tcs_pkg::CMD_TOUCH_ON}, tcs_pkg::ST_OK);
    check_byte("touch on", 8'h01, {7'h00, touch_enable_out});
    // stored calibration only takes effect after a power cycle
    do_reset(2'b01, 1'b1);
    check_byte("boot cce", 8'h01, {7'h00, calibrated_coords_enable_out});
    do_reset(2'b00, 1'b1);
    check_byte("boot cce off", 8'h00, {7'h00, calibrated_coords_enable_out});
    // interactive calibration with the host stalling every answer byte
    do_reset(2'b00, 1'b0);
    tcs_host_i.set_slow(1'b1);
    run({tcs_pkg::CMD_CAL_MODE, tcs_pkg::CAL_MODE_ARG}, tcs_pkg::ST_OK);
    check_byte("cal mode", 8'h01, {7'h00, cal_mode_out});
    // targets shown in order, next one only after the ack
    for (int c = 0; c < tcs_pkg::CORNERS; c++) begin
      @(posedge ref_clk_in) corner_touch_in <= 1'b1;
      @(posedge ref_clk_in) corner_touch_in <= 1'b0;
      tcs_host_i.get(r);
      chk_ack(r, tcs_pkg::ST_OK, tcs_pkg::CMD_CAL_MODE);
    end
    repeat (2) @(posedge ref_clk_in);
    check_byte("store request", 8'h01, {7'h00, cal_store_req_out});
    repeat (20) @(posedge ref_clk_in);
    @(posedge ref_clk_in) cal_store_done_in <= 1'b1;
    @(posedge ref_clk_in) cal_store_done_in <= 1'b0;
    // this variant reports completion, so no fixed wait is needed
    tcs_host_i.get(r);
    chk_ack(r, tcs_pkg::ST_OK, tcs_pkg::CMD_CAL_MODE);
    check_byte("cal cce", 8'h01, {7'h00, calibrated_coords_enable_out});
    check_byte("cal mode off", 8'h00, {7'h00, cal_mode_out});
    run({tcs_pkg::CMD_TOUCH_ON}, tcs_pkg::ST_OK);
    print_verdict();
  end
endmodule // testbench
